/* File: rtl/lss_cfg.svh */
// constants for the threshold status and refresh timing block
// assumes a 25 MHz core clock and 8-bit command codes
`ifndef LSS_CFG_SVH
`define LSS_CFG_SVH

`define LSS_CMD_W         8
`define LSS_DATA_W        16
`define LSS_CMD_HIGH_TH   8'h01
`define LSS_CMD_LOW_TH    8'h02
`define LSS_CMD_PSAVE     8'h03
`define LSS_CMD_STATUS    8'h06
`define LSS_BIT_LOW_FLAG  15
`define LSS_BIT_HIGH_FLAG 14
`define LSS_BIT_PSAVE_ON  0
`define LSS_BIT_PSM_LO    1
`define LSS_BIT_PSM_HI    2
`define LSS_TH_RESET      16'h0000
`define LSS_CLK_PERIOD_NS 40
`define LSS_MS_NS         1000000
`define LSS_IV_W          13
`define LSS_BASE_IT0      13'd600
`define LSS_BASE_IT1      13'd700
`define LSS_BASE_IT2      13'd900
`define LSS_BASE_IT3      13'd1300
`define LSS_ADD_PSM1      13'd500
`define LSS_ADD_PSM2      13'd1500
`define LSS_ADD_PSM3      13'd3500
`define LSS_RES_W         9
`define LSS_RES_IT0       9'd288
`define LSS_RES_IT1       9'd144
`define LSS_RES_IT2       9'd72
`define LSS_RES_IT3       9'd36

`endif

/* File: rtl/lss_pkg.sv */
// types shared by the threshold status and refresh timing block
// assumes lss_cfg.svh supplies the numeric constants
package lss_pkg;
  typedef enum logic [1:0]
  {
    LSS_PSM_MODE1 = 2'b00,
    LSS_PSM_MODE2 = 2'b01,
    LSS_PSM_MODE3 = 2'b10,
    LSS_PSM_MODE4 = 2'b11
  } lss_psm_t;

  typedef enum logic [3:0]
  {
    LSS_IT_C0 = 4'b0000,
    LSS_IT_C1 = 4'b0001,
    LSS_IT_C2 = 4'b0010,
    LSS_IT_C3 = 4'b0011
  } lss_it_t;
endpackage

/* File: rtl/lss_status_refresh.sv */
// threshold crossing status register and power-save refresh timer
// assumes a command decoder on i_clk delivers register reads and writes
`timescale 1ns/1ps
`include "lss_cfg.svh"

module lss_status_refresh
  import lss_pkg::*;
#(
  parameter int CYC_PER_MS = `LSS_MS_NS / `LSS_CLK_PERIOD_NS
)
(
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  input  wire logic [`LSS_CMD_W-1:0]    i_reg_cmd,
  input  wire logic [`LSS_DATA_W-1:0]   i_reg_wdata,
  input  wire logic                     i_int_en,
  input  wire logic [1:0]               i_gain_sel,
  input  wire logic [3:0]               i_integration_time_sel,
  input  wire logic                     i_als_valid,
  input  wire logic [`LSS_DATA_W-1:0]   i_als_data,
  output logic      [`LSS_DATA_W-1:0]   o_reg_rdata,
  output logic                          o_reg_rvalid,
  output logic                          o_low_crossing_flag,
  output logic                          o_high_crossing_flag,
  output logic                          o_power_save_on,
  output logic                          o_refresh_pulse,
  output logic      [`LSS_RES_W-1:0]    o_resolution
);

  localparam int DIV_W = $clog2(CYC_PER_MS + 1);

  logic [`LSS_DATA_W-1:0] high_th_q;
  logic [`LSS_DATA_W-1:0] low_th_q;
  lss_psm_t               power_save_interval_sel_q;
  logic                   power_save_on_q;
  logic                   low_flag_q;
  logic                   high_flag_q;
  logic [DIV_W-1:0]       div_q;
  logic                   ms_tick;
  logic [`LSS_IV_W-1:0]   ms_cnt_q;
  logic [`LSS_IV_W-1:0]   interval_ms;
  logic                   wr_hi;
  logic                   wr_lo;
  logic                   wr_ps;
  logic                   rd_status;
  logic                   hit_low;
  logic                   hit_high;

  // gain is not part of the table lookup; only code 01 is characterised
  function automatic logic [`LSS_IV_W-1:0] refresh_ms
  (
    input logic [3:0] it,
    input lss_psm_t   power_save_interval_sel
  );
    logic [`LSS_IV_W-1:0] base;
    logic [`LSS_IV_W-1:0] add;
    base = `LSS_BASE_IT0;
    add  = '0;
    case (it)
      LSS_IT_C0: base = `LSS_BASE_IT0;
      LSS_IT_C1: base = `LSS_BASE_IT1;
      LSS_IT_C2: base = `LSS_BASE_IT2;
      LSS_IT_C3: base = `LSS_BASE_IT3;
      default:   base = `LSS_BASE_IT0;
    endcase
    case (power_save_interval_sel)
      LSS_PSM_MODE1: add = '0;
      LSS_PSM_MODE2: add = `LSS_ADD_PSM1;
      LSS_PSM_MODE3: add = `LSS_ADD_PSM2;
      LSS_PSM_MODE4: add = `LSS_ADD_PSM3;
      default:       add = '0;
    endcase
    return `LSS_IV_W'(base + add);
  endfunction

  // unlisted integration codes fall back to the coarsest resolution
  function automatic logic [`LSS_RES_W-1:0] resolution_of
  (
    input logic [3:0] it
  );
    logic [`LSS_RES_W-1:0] r;
    r = `LSS_RES_IT0;
    case (it)
      LSS_IT_C0: r = `LSS_RES_IT0;
      LSS_IT_C1: r = `LSS_RES_IT1;
      LSS_IT_C2: r = `LSS_RES_IT2;
      LSS_IT_C3: r = `LSS_RES_IT3;
      default:   r = `LSS_RES_IT0;
    endcase
    return r;
  endfunction

  assign wr_hi     = i_reg_wr && (i_reg_cmd == `LSS_CMD_HIGH_TH);
  assign wr_lo     = i_reg_wr && (i_reg_cmd == `LSS_CMD_LOW_TH);
  assign wr_ps     = i_reg_wr && (i_reg_cmd == `LSS_CMD_PSAVE);
  assign rd_status = i_reg_rd && (i_reg_cmd == `LSS_CMD_STATUS);
  // strict compare: data equal to a bound is still inside the window
  assign hit_low   = i_als_valid && i_int_en && (i_als_data < low_th_q);
  assign hit_high  = i_als_valid && i_int_en && (i_als_data > high_th_q);
  assign interval_ms = refresh_ms(i_integration_time_sel,
                                  power_save_interval_sel_q);

  // threshold bounds
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      high_th_q <= `LSS_TH_RESET;
      low_th_q  <= `LSS_TH_RESET;
    end
    else
    begin
      if (wr_hi)
        high_th_q <= i_reg_wdata;
      if (wr_lo)
        low_th_q <= i_reg_wdata;
    end
  end

  // power-save control
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      power_save_interval_sel_q <= LSS_PSM_MODE1;
      power_save_on_q           <= 1'b0;
    end
    else if (wr_ps)
    begin
      power_save_interval_sel_q <= lss_psm_t'(
        i_reg_wdata[`LSS_BIT_PSM_HI:`LSS_BIT_PSM_LO]);
      power_save_on_q <= i_reg_wdata[`LSS_BIT_PSAVE_ON];
    end
  end

  // crossing flags; a fresh crossing outranks the read clear
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      low_flag_q  <= 1'b0;
      high_flag_q <= 1'b0;
    end
    else
    begin
      if (hit_low)
        low_flag_q <= 1'b1;
      else if (rd_status)
        low_flag_q <= 1'b0;
      if (hit_high)
        high_flag_q <= 1'b1;
      else if (rd_status)
        high_flag_q <= 1'b0;
    end
  end

  // read port; status bits are never written by the host
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
      begin
        case (i_reg_cmd)
          `LSS_CMD_HIGH_TH: o_reg_rdata <= high_th_q;
          `LSS_CMD_LOW_TH:  o_reg_rdata <= low_th_q;
          `LSS_CMD_STATUS:
          begin
            o_reg_rdata <= '0;
            o_reg_rdata[`LSS_BIT_LOW_FLAG]  <= low_flag_q;
            o_reg_rdata[`LSS_BIT_HIGH_FLAG] <= high_flag_q;
          end
          default: o_reg_rdata <= '0;
        endcase
      end
    end
  end

  // millisecond enable; divider parked while power saving is off
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      div_q <= '0;
    else if (!power_save_on_q || ms_tick)
      div_q <= '0;
    else
      div_q <= DIV_W'(div_q + 1'b1);
  end

  assign ms_tick = power_save_on_q && (div_q == DIV_W'(CYC_PER_MS - 1));

  // refresh interval; >= guards against a shrinking interval mid-count
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ms_cnt_q        <= '0;
      o_refresh_pulse <= 1'b0;
    end
    else
    begin
      o_refresh_pulse <= 1'b0;
      if (!power_save_on_q)
        ms_cnt_q <= '0;
      else if (ms_tick)
      begin
        if (ms_cnt_q >= `LSS_IV_W'(interval_ms - 1'b1))
        begin
          ms_cnt_q        <= '0;
          o_refresh_pulse <= 1'b1;
        end
        else
          ms_cnt_q <= `LSS_IV_W'(ms_cnt_q + 1'b1);
      end
    end
  end

  // mirrored state outputs
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_low_crossing_flag  <= 1'b0;
      o_high_crossing_flag <= 1'b0;
      o_power_save_on      <= 1'b0;
      o_resolution         <= `LSS_RES_IT0;
    end
    else
    begin
      o_low_crossing_flag  <= low_flag_q;
      o_high_crossing_flag <= high_flag_q;
      o_power_save_on      <= power_save_on_q;
      o_resolution         <= resolution_of(i_integration_time_sel);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  low_set_a: assert property (
    hit_low |=> low_flag_q ##1 o_low_crossing_flag)
    else $error("low flag missed a crossing");

  high_set_a: assert property (
    hit_high |=> high_flag_q ##1 o_high_crossing_flag)
    else $error("high flag missed a crossing");

  read_clear_a: assert property (
    rd_status && !hit_low && !hit_high |=> !low_flag_q && !high_flag_q)
    else $error("status read did not clear flags");

  status_word_a: assert property (
    rd_status |=> o_reg_rvalid &&
      o_reg_rdata == {$past(low_flag_q), $past(high_flag_q), 14'h0000})
    else $error("status read word wrong");

  psave_wo_a: assert property (
    i_reg_rd && i_reg_cmd == `LSS_CMD_PSAVE |=> o_reg_rdata == '0)
    else $error("write-only register read back nonzero");

  flags_ro_a: assert property (
    i_reg_wr && i_reg_cmd == `LSS_CMD_STATUS && !high_flag_q && !hit_high
    |=> !high_flag_q)
    else $error("host write changed a flag");

  th_write_a: assert property (
    wr_hi |=> high_th_q == $past(i_reg_wdata))
    else $error("high bound not stored");

  low_write_a: assert property (
    wr_lo |=> low_th_q == $past(i_reg_wdata))
    else $error("low bound not stored");

  table_it0_a: assert property (
    i_integration_time_sel == 4'h0 &&
    power_save_interval_sel_q == LSS_PSM_MODE4 |-> interval_ms == 13'd4100)
    else $error("refresh interval wrong for code 0000");

  table_it1_a: assert property (
    i_integration_time_sel == 4'h1 &&
    power_save_interval_sel_q == LSS_PSM_MODE2 |-> interval_ms == 13'd1200)
    else $error("refresh interval wrong for code 0001");

  table_it2_a: assert property (
    i_integration_time_sel == 4'h2 &&
    power_save_interval_sel_q == LSS_PSM_MODE3 |-> interval_ms == 13'd2400)
    else $error("refresh interval wrong for code 0010");

  table_it3_a: assert property (
    i_integration_time_sel == 4'h3 &&
    power_save_interval_sel_q == LSS_PSM_MODE1 |-> interval_ms == 13'd1300)
    else $error("refresh interval wrong for code 0011");

  refresh_off_a: assert property (
    !power_save_on_q |=> !o_refresh_pulse)
    else $error("refresh pulse with power saving off");

  resolution_a: assert property (
    i_integration_time_sel == 4'h3 |=> o_resolution == 9'd36)
    else $error("resolution wrong for code 0011");

  refresh_seen_c: cover property (o_refresh_pulse);
  set_wins_c: cover property (rd_status && hit_high);
  both_flags_c: cover property (low_flag_q && high_flag_q);
  status_read_c: cover property (rd_status && low_flag_q);

endmodule

/* File: testbench/lss_host.sv */
// host controller model driving the register access port
// assumes falling-edge stimulus and a one-cycle read answer
`timescale 1ns/1ps
module lss_host
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_cmd,
  output logic [15:0]      o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_cmd = 8'h00;
    o_wdata = 16'h0000;
  end

  // released lines show the inverse, not a stale copy
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge i_clk);
    o_cmd = c;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_cmd = ~c;
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] d,
                    output logic v);
    @(negedge i_clk);
    o_cmd = c;
    o_rd = 1'b1;
    // answer strobe stands for one cycle only; take it before release
    @(negedge i_clk);
    d = i_rdata;
    v = i_rvalid;
    o_rd = 1'b0;
    o_cmd = ~c;
  endtask
endmodule

/* File: testbench/lss_status_refresh_test.sv */
// self-checking bench for the status register and refresh timer
// assumes a shortened millisecond divider to keep the run short
`timescale 1ns/1ps
module lss_status_refresh_test;
  localparam int CPM = 2;
  logic        clk, rst, wr, rd, int_en, av, rv, lo, hi, ps, pl;
  logic [7:0]  cmd;
  logic [15:0] wd, ad, rdat, d;
  logic [3:0]  it;
  logic [8:0]  res;
  logic        v;
  int          n_fail, compares, n;
  // every integration row and every mode at least once; short rows keep run short
  logic [1:0]  tp[8] = '{2'd0, 2'd1, 2'd3, 2'd1, 2'd2, 2'd0, 2'd0, 2'd0};
  logic [3:0]  ti[8] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h1, 4'h2, 4'h3};
  int          tm[8] = '{600, 1100, 4100, 1200, 2400, 700, 900, 1300};
  logic [8:0]  tr[4] = '{9'd288, 9'd144, 9'd72, 9'd36};

  lss_status_refresh #(.CYC_PER_MS(CPM)) u_dut
  (
    .i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_cmd(cmd), .i_reg_wdata(wd), .i_int_en(int_en),
    .i_gain_sel(2'b01), .i_integration_time_sel(it),
    .i_als_valid(av), .i_als_data(ad), .o_reg_rdata(rdat),
    .o_reg_rvalid(rv), .o_low_crossing_flag(lo),
    .o_high_crossing_flag(hi), .o_power_save_on(ps),
    .o_refresh_pulse(pl), .o_resolution(res)
  );

  lss_host u_host
  (
    .i_clk(clk), .i_rdata(rdat), .i_rvalid(rv), .o_wr(wr),
    .o_rd(rd), .o_cmd(cmd), .o_wdata(wd)
  );

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // read and compare word and answer strobe together
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    u_host.rd(c, d, v);
    chk("rdata", d, e);
    chk("rvalid", v, 1);
  endtask

  // sample lands two edges later on the flag outputs
  task automatic smp(input logic [15:0] x);
    @(negedge clk);
    ad = x;
    av = 1'b1;
    @(negedge clk);
    av = 1'b0;
    @(negedge clk);
  endtask

  // bounded wait; counts falling edges up to the next pulse
  task automatic wpl(output int k, input int lim);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (pl !== 1'b1 && k < lim);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #(90000 * 40);
    n_fail++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    int_en = 1'b0;
    av = 1'b0;
    ad = 16'h0000;
    it = 4'h0;
    n_fail = 0;
    compares = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rchk(8'h06, 16'h0000);
    chk("pson", ps, 0);
    $display("reset test done");
    for (int k = 0; k < 4; k++)
    begin
      it = k[3:0];
      repeat (2) @(negedge clk);
      chk("res", res, tr[k]);
    end
    $display("resolution test done");
    u_host.wr(8'h01, 16'h03e8);
    u_host.wr(8'h02, 16'h0064);
    rchk(8'h01, 16'h03e8);
    rchk(8'h02, 16'h0064);
    int_en = 1'b1;
    smp(16'h0064);
    smp(16'h03e8);
    chk("edge", {lo, hi}, 0);
    smp(16'h0063);
    chk("low", {lo, hi}, 2'b10);
    smp(16'h03e9);
    chk("high", {lo, hi}, 2'b11);
    rchk(8'h06, 16'hc000);
    rchk(8'h06, 16'h0000);
    chk("clear", {lo, hi}, 0);
    smp(16'hffff);
    rchk(8'h06, 16'h4000);
    // read and crossing in one cycle: old word out, flag kept
    fork
      u_host.rd(8'h06, d, v);
      smp(16'hffff);
    join
    chk("race", d, 16'h0000);
    rchk(8'h06, 16'h4000);
    int_en = 1'b0;
    smp(16'h0000);
    u_host.wr(8'h06, 16'hffff);
    rchk(8'h06, 16'h0000);
    rchk(8'h03, 16'h0000);
    $display("status test done");
    for (int k = 0; k < 8; k++)
    begin
      it = ti[k];
      u_host.wr(8'h03, {13'h0000, tp[k], 1'b1});
      @(negedge clk);
      chk("pson", ps, 1);
      wpl(n, 20000);
      wpl(n, 20000);
      chk("period", n, tm[k] * CPM);
      u_host.wr(8'h03, 16'h0000);
      // one full interval: a counter left running would pulse in here
      wpl(n, tm[k] * CPM + 8);
      chk("idle", pl, 0);
    end
    $display("refresh test done");
    finish_test();
  end
endmodule
